// [snrc_far_node.sv]
// far switch node model: answers credit requests, injects receive faults
`timescale 1ns/1ps
`default_nettype none
module snrc_far_node (
	// clock and answer speed
	input wire logic clk,
	input wire logic slow,
	// link control seen from the node
	input wire logic [7:0] link_enable,
	input wire logic [7:0] credit_req,
	input wire logic [7:0] err_cmd,
	// link state returned to the node
	output logic [7:0] credit_issued,
	output logic [7:0] credit_gain,
	output logic [7:0] rx_error
);
	logic [7:0] pend [0:5];
	// an enabled link has had credit handed over to it
	assign credit_issued = link_enable;
	initial begin
		credit_gain = 8'h00;
		rx_error = 8'h00;
		foreach (pend[i]) pend[i] = 8'h00;
	end
	// slow answers come late enough to see the cleared credit first
	always @(posedge clk) begin
		pend[0] <= credit_req;
		for (int i = 1; i < 6; i++) pend[i] <= pend[i-1];
		credit_gain <= slow ? pend[5] : credit_req;
		rx_error <= err_cmd;
	end
endmodule
`default_nettype wire

// [snrc_pacer.sv]
// per-link transmit pacer holding idle gaps between symbols and tokens
`timescale 1ns/1ps
`default_nettype none
module snrc_pacer (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// symbol request from the transmitter
	input wire logic sym_req,
	input wire logic sym_last,
	output logic sym_go,
	// gap settings, idle clocks minus one
	input wire logic [10:0] sym_gap,
	input wire logic [10:0] tok_gap
);
	logic [11:0] wait_reg;

	assign sym_go = sym_req && (wait_reg == 12'h000);

	// at least gap+1 idle clocks follow every sent symbol
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 12'h000;
		end else if (sym_go) begin
			if (sym_last) begin
				wait_reg <= {1'b0, tok_gap} + 12'h001;
			end else begin
				wait_reg <= {1'b0, sym_gap} + 12'h001;
			end
		end else if (wait_reg != 12'h000) begin
			wait_reg <= wait_reg - 12'h001;
		end
	end
endmodule
`default_nettype wire

// [snrc_pkg.sv]
// constants for the switch node routing and configuration block
package snrc_pkg;
	localparam int NLINK = 8;
	// register numbers as used on the configuration port
	localparam logic [7:0] SW_CONFIG = 8'h04;
	localparam logic [7:0] NODE_ID = 8'h05;
	localparam logic [7:0] SW_CLK_DIV = 8'h07;
	localparam logic [7:0] REF_CLK_DIV = 8'h08;
	localparam logic [7:0] SCAN_ID = 8'h09;
	localparam logic [7:0] USER_CODE = 8'h0a;
	localparam logic [7:0] DIRS_LOW = 8'h0c;
	localparam logic [7:0] DIRS_HIGH = 8'h0d;
	localparam logic [7:0] SPARE_A = 8'h10;
	localparam logic [7:0] SPARE_B = 8'h11;
	localparam logic [7:0] DBG_ORIGIN = 8'h1f;
	localparam logic [7:0] EXT_STATE_BASE = 8'h20;
	localparam logic [7:0] CORE_STATE_BASE = 8'h40;
	localparam logic [7:0] EXT_SETUP_BASE = 8'h80;
	localparam logic [7:0] LINK_IDX_MASK = 8'hf8;
	// reset values
	localparam logic [15:0] SW_DIV_RESET = 16'h0000;
	localparam logic [15:0] REF_DIV_RESET = 16'h0003;
	// field positions
	localparam int WP_BIT = 31;
	localparam int UC_USER_LSB = 18;
	localparam int DBG_SPARE_BIT = 4;
	localparam int ST_KIND_LSB = 24;
	localparam int ST_DEST_LSB = 16;
	localparam int ST_DIR_LSB = 8;
	localparam int ST_NET_LSB = 4;
	localparam int ST_JUNK_BIT = 2;
	localparam int ST_DBUSY_BIT = 1;
	localparam int ST_SBUSY_BIT = 0;
	localparam int CF_EN_BIT = 31;
	localparam int CF_WIDE_BIT = 30;
	localparam int CF_ERR_BIT = 27;
	localparam int CF_ISSUED_BIT = 26;
	localparam int CF_HOLD_BIT = 25;
	localparam int CF_CREDIT_REQUEST_TOKEN_BIT = 24;
	localparam int CF_RXRST_BIT = 23;
	localparam int CF_SYMGAP_LSB = 11;
	localparam int CF_TOKGAP_LSB = 0;
	localparam int GAP_W = 11;
	// identity values, arbitrary
	localparam logic [31:0] SCAN_ID_VALUE = 32'h0000_1001;
	localparam logic [13:0] USER_VALUE = 14'h0000;
	localparam logic [17:0] METAL_ID_VALUE = 18'h00001;
endpackage

// [snrc_tb_top.sv]
// self-checking bench for the switch node routing and configuration block
`timescale 1ns/1ps
`default_nettype none
module snrc_tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [31:0] cfg_wdata = 32'h0;
	logic route_req = 1'b0;
	logic [15:0] route_target = 16'h0;
	logic dbg0 = 1'b0;
	logic dbg1 = 1'b0;
	logic far_slow = 1'b0;
	logic [15:0] ext_kind = 16'h0;
	logic [15:0] proc_kind = 16'h0;
	logic [63:0] ext_dest = 64'h0;
	logic [63:0] proc_dest = 64'h0;
	logic [7:0] ext_junk = 8'h0;
	logic [7:0] ext_busy = 8'h0;
	logic [7:0] proc_junk = 8'h0;
	logic [7:0] proc_busy = 8'h0;
	logic [7:0] sym_req = 8'h0;
	logic [7:0] sym_last = 8'h0;
	logic [7:0] err_cmd = 8'h0;
	logic [31:0] cfg_rdata, ext_dir, r, e4;
	logic cfg_rvalid, route_valid, route_local, sw_tick, ref_tick;
	logic [3:0] route_dir;
	logic [15:0] ext_net, proc_net, t, id;
	logic [7:0] l_en, l_five, l_err, l_iss, l_gain, l_creq, l_rxr, sym_go, a;
	logic [31:0] rng = 32'h0000eb3f;
	logic [31:0] mdl [0:255];
	logic [7:0] rw_list [0:22] = '{8'h05, 8'h07, 8'h08, 8'h0c, 8'h0d, 8'h10,
		8'h11, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
		8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
	logic [7:0] rst_list [0:11] = '{8'h05, 8'h07, 8'h08, 8'h0c, 8'h0d,
		8'h10, 8'h11, 8'h20, 8'h40, 8'h80, 8'h28, 8'h88};
	int miscompares = 0;
	int cmp_count = 0;
	int creq_cnt = 0;
	int rxr_cnt = 0;
	int n, d;

	snrc_top dut (
		.clk(clk), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid), .route_req(route_req),
		.route_target(route_target), .route_valid(route_valid),
		.route_local(route_local), .route_dir(route_dir),
		.switch_clk_tick(sw_tick), .ref_clk_tick(ref_tick),
		.dbg_core0_event(dbg0), .dbg_core1_event(dbg1),
		.ext_kind(ext_kind), .ext_dest(ext_dest), .ext_junk(ext_junk),
		.ext_dst_busy(ext_busy), .ext_src_busy(ext_busy),
		.ext_dir(ext_dir), .ext_net(ext_net), .proc_kind(proc_kind),
		.proc_dest(proc_dest), .proc_junk(proc_junk),
		.proc_dst_busy(proc_busy), .proc_src_busy(proc_busy),
		.proc_net(proc_net), .link_enable(l_en), .link_five_wire(l_five),
		.link_rx_error(l_err), .link_credit_issued(l_iss),
		.link_credit_gain(l_gain), .link_credit_request(l_creq),
		.link_rx_reset(l_rxr), .tx_sym_req(sym_req),
		.tx_sym_last(sym_last), .tx_sym_go(sym_go)
	);
	snrc_far_node far (
		.clk(clk), .slow(far_slow), .link_enable(l_en), .credit_req(l_creq),
		.err_cmd(err_cmd), .credit_issued(l_iss), .credit_gain(l_gain),
		.rx_error(l_err)
	);

	always #25 clk = ~clk;
	always @(posedge clk) begin
		creq_cnt += $countones(l_creq);
		rxr_cnt += $countones(l_rxr);
	end

	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [31:0] wm(input logic [7:0] ad);
		case (ad) inside
			8'h05, 8'h07, 8'h08: return 32'h0000ffff;
			8'h0c, 8'h0d: return 32'hffffffff;
			8'h10, 8'h11: return 32'h00000003;
			[8'h20:8'h27]: return 32'h00000f30;
			[8'h40:8'h47]: return 32'h00000030;
			default: return 32'h0;
		endcase
	endfunction
	function automatic logic [31:0] sx(input logic [31:0] m, input logic e, h);
		return {m[31:30], 2'b00, e, m[31], h, 3'b000, m[21:0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] ex, got);
		cmp_count++;
		if (got !== ex) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_addr = ad;
		cfg_wdata = dt;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask
	task automatic rdc(input logic [7:0] ad, input logic [31:0] ex);
		@(negedge clk);
		cfg_rd = 1'b1;
		cfg_addr = ad;
		@(negedge clk);
		cfg_rd = 1'b0;
		chk("read valid", 32'h1, {31'h0, cfg_rvalid});
		chk($sformatf("register %h", ad), ex, cfg_rdata);
	endtask
	// spacing between two successive symbol launches on link 0
	task automatic gap(input logic last, input int ex);
		int k;
		sym_last[0] = last;
		sym_req[0] = 1'b1;
		k = 0;
		do @(negedge clk); while (sym_go[0] !== 1'b1 && ++k < 40);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (sym_go[0] !== 1'b1 && k < 40);
		chk("symbol spacing", 32'(ex), 32'(k));
	endtask
	task automatic close_out();
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#2000000;
		miscompares++;
		close_out();
	end

	initial begin
		foreach (mdl[i]) mdl[i] = 32'h0;
		mdl[8] = 32'h3;
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		foreach (rst_list[i]) rdc(rst_list[i], mdl[rst_list[i]]);
		rdc(8'h09, snrc_pkg::SCAN_ID_VALUE);
		rdc(8'h0a, {snrc_pkg::USER_VALUE, snrc_pkg::METAL_ID_VALUE});
		foreach (rw_list[i]) begin
			a = rw_list[i];
			r = rnd();
			wr(a, r);
			mdl[a] = r & wm(a);
			rdc(a, mdl[a]);
		end
		wr(8'h09, rnd());
		rdc(8'h09, snrc_pkg::SCAN_ID_VALUE);
		for (n = 0; n < 8; n++) begin
			chk("link dir", {28'h0, mdl[32+n][11:8]}, {28'h0, ext_dir[4*n+:4]});
			chk("link net", {30'h0, mdl[32+n][5:4]}, {30'h0, ext_net[2*n+:2]});
			chk("core net", {30'h0, mdl[64+n][5:4]}, {30'h0, proc_net[2*n+:2]});
		end
		// busy drives both sides, so the in-use reading of dest is unambiguous
		for (n = 0; n < 16; n++) begin
			a = (n < 8) ? 8'(8'h20 + n) : 8'(8'h38 + n);
			r = rnd();
			if (n < 8) begin
				ext_kind[2*n+:2] = r[1:0];
				ext_dest[8*n+:8] = r[15:8];
				ext_junk[n] = r[2];
				ext_busy[n] = r[3];
			end else begin
				proc_kind[2*(n-8)+:2] = r[1:0];
				proc_dest[8*(n-8)+:8] = r[15:8];
				proc_junk[n-8] = r[2];
				proc_busy[n-8] = r[3];
			end
			rdc(a, {6'h0, r[1:0], r[3] ? r[15:8] : 8'h0, mdl[a][15:0] | {13'h0, r[2], r[3], r[3]}});
		end
		id = mdl[5][15:0];
		for (d = -1; d < 16; d++) begin
			r = rnd();
			t = (d < 0) ? id : id ^ (16'h1 << d) ^ (r[15:0] & ((16'h1 << d) - 16'h1));
			e4 = (d > 7) ? mdl[13] >> (4 * (d - 8)) : mdl[12] >> (4 * d);
			@(negedge clk);
			route_req = 1'b1;
			route_target = t;
			@(negedge clk);
			route_req = 1'b0;
			chk("route valid", 32'h1, {31'h0, route_valid});
			chk("route local", {31'h0, d < 0}, {31'h0, route_local});
			if (d >= 0) chk("route dir", {28'h0, e4[3:0]}, {28'h0, route_dir});
		end
		dbg0 = 1'b1;
		@(negedge clk);
		dbg0 = 1'b0;
		rdc(8'h1f, 32'h1);
		dbg1 = 1'b1;
		@(negedge clk);
		dbg1 = 1'b0;
		rdc(8'h1f, 32'h2);
		wr(8'h07, 32'h2);
		wr(8'h08, 32'h3);
		n = 0;
		d = 0;
		repeat (12) begin
			@(negedge clk);
			n += (sw_tick === 1'b1);
			d += (ref_tick === 1'b1);
		end
		chk("switch ticks", 32'h4, 32'(n));
		chk("reference ticks", 32'h3, 32'(d));
		for (n = 0; n < 8; n++) begin
			far_slow = n[0];
			a = 8'(8'h80 + n);
			mdl[a] = (rnd() & 32'hc03fffff) | 32'h80000000;
			wr(a, mdl[a]);
			rdc(a, sx(mdl[a], 1'b0, 1'b0));
			chk("enable", 32'h1, {31'h0, l_en[n]});
			chk("five wire", {31'h0, mdl[a][30]}, {31'h0, l_five[n]});
			wr(a, mdl[a] | 32'h01000000);
			if (far_slow) rdc(a, sx(mdl[a], 1'b0, 1'b0));
			repeat (10) @(negedge clk);
			rdc(a, sx(mdl[a], 1'b0, 1'b1));
			err_cmd[n] = 1'b1;
			@(negedge clk);
			err_cmd[n] = 1'b0;
			repeat (3) @(negedge clk);
			rdc(a, sx(mdl[a], 1'b1, 1'b1));
			wr(a, mdl[a] | 32'h00800000);
			repeat (3) @(negedge clk);
			rdc(a, sx(mdl[a], 1'b0, 1'b1));
		end
		chk("credit requests", 32'h8, 32'(creq_cnt));
		chk("receiver resets", 32'h8, 32'(rxr_cnt));
		wr(8'h80, 32'h80001004);
		gap(1'b0, 4);
		gap(1'b1, 6);
		wr(8'h80, 32'h00001004);
		n = 0;
		repeat (10) begin
			@(negedge clk);
			n += (sym_go[0] !== 1'b0);
		end
		chk("disabled link sends", 32'h0, 32'(n));
		sym_req[0] = 1'b0;
		wr(8'h04, 32'h80000000);
		wr(8'h05, rnd());
		wr(8'h0c, rnd());
		rdc(8'h05, mdl[5]);
		rdc(8'h0c, mdl[12]);
		close_out();
	end
endmodule
`default_nettype wire

// [snrc_top.sv]
// switch node routing and configuration registers
// Functional notes
// - switch clock tick derived from PLL clock via 16-bit divider, reset zero
// - reference clock tick derived via 16-bit divider resetting to three
// - read-only user code: user value in 31:18, metal ID in 17:0
// - low direction table: eight 4-bit fields for dimensions 0 to 7
// - high direction table: eight 4-bit fields for dimensions 8 to 15
// - packets route by direction of most significant mismatching ID bit
// - 16-bit node identifier, read-write, reset zero, used for routing
// - debug origin bits 1 and 0 show which core raised latest event
// - link status bits 25:24 show connected unit kind
// - bits 23:16 show destination link while link is in use
// - external link status holds 4-bit read-write direction in 11:8
// - link status holds 2-bit network number in 5:4, reset zero
// - status bits: 2 junk packet, 1 dest busy, 0 source busy
// - eight processor link status registers without direction field
// - setup bit 31 enables or disables the external link
// - setup bit 30 selects two-wire or five-wire mode, reset zero
// - bit 27 set on receive overflow or illegal token
// - bit 26 credit issued, bit 25 credit held, both reset zero
// - writing bit 24 clears held credit and sends credit request
// - writing bit 23 resets link receiver
// - at least symbol gap plus one idle clocks between symbols
// - at least token gap plus one idle clocks between tokens
// - write-protect bit 31 of switch config blocks further writes
`timescale 1ns/1ps
`default_nettype none
module snrc_top (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// configuration access port
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// route lookup
	input wire logic route_req,
	input wire logic [15:0] route_target,
	output logic route_valid,
	output logic route_local,
	output logic [3:0] route_dir,
	// derived clock ticks
	output logic switch_clk_tick,
	output logic ref_clk_tick,
	// debug events
	input wire logic dbg_core0_event,
	input wire logic dbg_core1_event,
	// external link state
	input wire logic [15:0] ext_kind,
	input wire logic [63:0] ext_dest,
	input wire logic [7:0] ext_junk,
	input wire logic [7:0] ext_dst_busy,
	input wire logic [7:0] ext_src_busy,
	output logic [31:0] ext_dir,
	output logic [15:0] ext_net,
	// processor link state
	input wire logic [15:0] proc_kind,
	input wire logic [63:0] proc_dest,
	input wire logic [7:0] proc_junk,
	input wire logic [7:0] proc_dst_busy,
	input wire logic [7:0] proc_src_busy,
	output logic [15:0] proc_net,
	// external link control
	output logic [7:0] link_enable,
	output logic [7:0] link_five_wire,
	input wire logic [7:0] link_rx_error,
	input wire logic [7:0] link_credit_issued,
	input wire logic [7:0] link_credit_gain,
	output logic [7:0] link_credit_request,
	output logic [7:0] link_rx_reset,
	// transmit pacing
	input wire logic [7:0] tx_sym_req,
	input wire logic [7:0] tx_sym_last,
	output logic [7:0] tx_sym_go
);
	logic rst_meta_reg;
	logic rst_n;
	logic wp_reg;
	logic [15:0] node_id_reg;
	logic [15:0] sw_div_reg;
	logic [15:0] ref_div_reg;
	logic [15:0] sw_cnt_reg;
	logic [15:0] ref_cnt_reg;
	logic [31:0] dirs_lo_reg;
	logic [31:0] dirs_hi_reg;
	logic [1:0] spare_a_reg;
	logic [1:0] spare_b_reg;
	logic [1:0] dbg_src_reg;
	logic dbg_spare_reg;
	logic [7:0] enable_reg;
	logic [7:0] wide_reg;
	logic [7:0] err_reg;
	logic [7:0] hold_reg;
	logic [87:0] sym_gap_reg;
	logic [87:0] tok_gap_reg;
	logic [31:0] rd_next;
	logic wr_ok;
	logic [2:0] li;
	logic hit_ext_st;
	logic hit_core_st;
	logic hit_setup;
	logic [15:0] mismatch;
	logic [3:0] msb_idx;
	logic [3:0] dir_next;

	// reset is released through two flops so removal is clean
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	assign li = cfg_addr[2:0];
	assign hit_ext_st = (cfg_addr & snrc_pkg::LINK_IDX_MASK) ==
		snrc_pkg::EXT_STATE_BASE;
	assign hit_core_st = (cfg_addr & snrc_pkg::LINK_IDX_MASK) ==
		snrc_pkg::CORE_STATE_BASE;
	assign hit_setup = (cfg_addr & snrc_pkg::LINK_IDX_MASK) ==
		snrc_pkg::EXT_SETUP_BASE;
	// the protect bit locks itself too, so only reset unlocks
	assign wr_ok = cfg_wr && !wp_reg;

	// node-wide control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg <= 1'b0;
			node_id_reg <= 16'h0000;
			sw_div_reg <= snrc_pkg::SW_DIV_RESET;
			ref_div_reg <= snrc_pkg::REF_DIV_RESET;
			dirs_lo_reg <= 32'h0000_0000;
			dirs_hi_reg <= 32'h0000_0000;
			spare_a_reg <= 2'h0;
			spare_b_reg <= 2'h0;
		end else if (wr_ok) begin
			if (cfg_addr == snrc_pkg::SW_CONFIG) begin
				wp_reg <= cfg_wdata[snrc_pkg::WP_BIT];
			end else if (cfg_addr == snrc_pkg::NODE_ID) begin
				node_id_reg <= cfg_wdata[15:0];
			end else if (cfg_addr == snrc_pkg::SW_CLK_DIV) begin
				sw_div_reg <= cfg_wdata[15:0];
			end else if (cfg_addr == snrc_pkg::REF_CLK_DIV) begin
				ref_div_reg <= cfg_wdata[15:0];
			end else if (cfg_addr == snrc_pkg::DIRS_LOW) begin
				dirs_lo_reg <= cfg_wdata;
			end else if (cfg_addr == snrc_pkg::DIRS_HIGH) begin
				dirs_hi_reg <= cfg_wdata;
			end else if (cfg_addr == snrc_pkg::SPARE_A) begin
				spare_a_reg <= cfg_wdata[1:0];
			end else if (cfg_addr == snrc_pkg::SPARE_B) begin
				spare_b_reg <= cfg_wdata[1:0];
			end
		end
	end

	// clock dividers: a tick every divider+1 PLL clocks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_cnt_reg <= 16'h0000;
			ref_cnt_reg <= 16'h0000;
		end else begin
			sw_cnt_reg <= (sw_cnt_reg >= sw_div_reg) ? 16'h0000 :
				sw_cnt_reg + 16'h0001;
			ref_cnt_reg <= (ref_cnt_reg >= ref_div_reg) ? 16'h0000 :
				ref_cnt_reg + 16'h0001;
		end
	end
	assign switch_clk_tick = rst_n && (sw_cnt_reg >= sw_div_reg);
	assign ref_clk_tick = rst_n && (ref_cnt_reg >= ref_div_reg);

	// debug origin: an event in the same cycle as a write wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dbg_src_reg <= 2'h0;
			dbg_spare_reg <= 1'b0;
		end else begin
			if (dbg_core0_event || dbg_core1_event) begin
				dbg_src_reg <= {dbg_core1_event, dbg_core0_event};
			end else if (wr_ok && cfg_addr == snrc_pkg::DBG_ORIGIN) begin
				dbg_src_reg <= cfg_wdata[1:0];
			end
			if (wr_ok && cfg_addr == snrc_pkg::DBG_ORIGIN) begin
				dbg_spare_reg <= cfg_wdata[snrc_pkg::DBG_SPARE_BIT];
			end
		end
	end

	// per-link direction and network fields
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_dir <= 32'h0000_0000;
			ext_net <= 16'h0000;
			proc_net <= 16'h0000;
		end else if (wr_ok && hit_ext_st) begin
			ext_dir[li*4 +: 4] <=
				cfg_wdata[snrc_pkg::ST_DIR_LSB +: 4];
			ext_net[li*2 +: 2] <=
				cfg_wdata[snrc_pkg::ST_NET_LSB +: 2];
		end else if (wr_ok && hit_core_st) begin
			proc_net[li*2 +: 2] <=
				cfg_wdata[snrc_pkg::ST_NET_LSB +: 2];
		end
	end

	// link setup: enable, width, gaps, and one-shot commands
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= 8'h00;
			wide_reg <= 8'h00;
			sym_gap_reg <= 88'h0;
			tok_gap_reg <= 88'h0;
			link_credit_request <= 8'h00;
			link_rx_reset <= 8'h00;
		end else begin
			link_credit_request <= 8'h00;
			link_rx_reset <= 8'h00;
			if (wr_ok && hit_setup) begin
				enable_reg[li] <= cfg_wdata[snrc_pkg::CF_EN_BIT];
				wide_reg[li] <= cfg_wdata[snrc_pkg::CF_WIDE_BIT];
				sym_gap_reg[li*11 +: 11] <=
					cfg_wdata[snrc_pkg::CF_SYMGAP_LSB +: 11];
				tok_gap_reg[li*11 +: 11] <=
					cfg_wdata[snrc_pkg::CF_TOKGAP_LSB +: 11];
				link_credit_request[li] <=
					cfg_wdata[snrc_pkg::CF_CREDIT_REQUEST_TOKEN_BIT];
				link_rx_reset[li] <= cfg_wdata[snrc_pkg::CF_RXRST_BIT];
			end
		end
	end
	assign link_enable = enable_reg;
	assign link_five_wire = wide_reg;

	// sticky error and held credit; hardware set wins over the clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_reg <= 8'h00;
			hold_reg <= 8'h00;
		end else begin
			for (int i = 0; i < snrc_pkg::NLINK; i++) begin
				if (link_rx_error[i]) begin
					err_reg[i] <= 1'b1;
				end else if (link_rx_reset[i]) begin
					err_reg[i] <= 1'b0;
				end
				if (link_credit_gain[i]) begin
					hold_reg[i] <= 1'b1;
				end else if (wr_ok && hit_setup && li == i[2:0] &&
					cfg_wdata[snrc_pkg::CF_CREDIT_REQUEST_TOKEN_BIT]) begin
					hold_reg[i] <= 1'b0;
				end
			end
		end
	end

	// routing by the highest differing identifier bit
	assign mismatch = route_target ^ node_id_reg;
	always_comb begin
		msb_idx = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (mismatch[i]) begin
				msb_idx = i[3:0];
			end
		end
		if (msb_idx[3]) begin
			dir_next = dirs_hi_reg[msb_idx[2:0]*4 +: 4];
		end else begin
			dir_next = dirs_lo_reg[msb_idx[2:0]*4 +: 4];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			route_valid <= 1'b0;
			route_local <= 1'b0;
			route_dir <= 4'h0;
		end else begin
			route_valid <= route_req;
			if (route_req) begin
				route_local <= (mismatch == 16'h0000);
				route_dir <= dir_next;
			end
		end
	end

	// read mux; reserved and write-only bits read as zero
	always_comb begin
		rd_next = 32'h0000_0000;
		if (cfg_addr == snrc_pkg::SW_CONFIG) begin
			rd_next[snrc_pkg::WP_BIT] = wp_reg;
		end else if (cfg_addr == snrc_pkg::NODE_ID) begin
			rd_next[15:0] = node_id_reg;
		end else if (cfg_addr == snrc_pkg::SW_CLK_DIV) begin
			rd_next[15:0] = sw_div_reg;
		end else if (cfg_addr == snrc_pkg::REF_CLK_DIV) begin
			rd_next[15:0] = ref_div_reg;
		end else if (cfg_addr == snrc_pkg::SCAN_ID) begin
			rd_next = snrc_pkg::SCAN_ID_VALUE;
		end else if (cfg_addr == snrc_pkg::USER_CODE) begin
			rd_next = {snrc_pkg::USER_VALUE,
				snrc_pkg::METAL_ID_VALUE};
		end else if (cfg_addr == snrc_pkg::DIRS_LOW) begin
			rd_next = dirs_lo_reg;
		end else if (cfg_addr == snrc_pkg::DIRS_HIGH) begin
			rd_next = dirs_hi_reg;
		end else if (cfg_addr == snrc_pkg::SPARE_A) begin
			rd_next[1:0] = spare_a_reg;
		end else if (cfg_addr == snrc_pkg::SPARE_B) begin
			rd_next[1:0] = spare_b_reg;
		end else if (cfg_addr == snrc_pkg::DBG_ORIGIN) begin
			rd_next[snrc_pkg::DBG_SPARE_BIT] = dbg_spare_reg;
			rd_next[1:0] = dbg_src_reg;
		end else if (hit_ext_st) begin
			rd_next[snrc_pkg::ST_KIND_LSB +: 2] = ext_kind[li*2 +: 2];
			if (ext_src_busy[li] || ext_dst_busy[li]) begin
				rd_next[snrc_pkg::ST_DEST_LSB +: 8] =
					ext_dest[li*8 +: 8];
			end
			rd_next[snrc_pkg::ST_DIR_LSB +: 4] = ext_dir[li*4 +: 4];
			rd_next[snrc_pkg::ST_NET_LSB +: 2] = ext_net[li*2 +: 2];
			rd_next[snrc_pkg::ST_JUNK_BIT] = ext_junk[li];
			rd_next[snrc_pkg::ST_DBUSY_BIT] = ext_dst_busy[li];
			rd_next[snrc_pkg::ST_SBUSY_BIT] = ext_src_busy[li];
		end else if (hit_core_st) begin
			rd_next[snrc_pkg::ST_KIND_LSB +: 2] = proc_kind[li*2 +: 2];
			if (proc_src_busy[li] || proc_dst_busy[li]) begin
				rd_next[snrc_pkg::ST_DEST_LSB +: 8] = proc_dest[li*8 +: 8];
			end
			rd_next[snrc_pkg::ST_NET_LSB +: 2] = proc_net[li*2 +: 2];
			rd_next[snrc_pkg::ST_JUNK_BIT] = proc_junk[li];
			rd_next[snrc_pkg::ST_DBUSY_BIT] = proc_dst_busy[li];
			rd_next[snrc_pkg::ST_SBUSY_BIT] = proc_src_busy[li];
		end else if (hit_setup) begin
			rd_next[snrc_pkg::CF_EN_BIT] = enable_reg[li];
			rd_next[snrc_pkg::CF_WIDE_BIT] = wide_reg[li];
			rd_next[snrc_pkg::CF_ERR_BIT] = err_reg[li];
			rd_next[snrc_pkg::CF_ISSUED_BIT] = link_credit_issued[li];
			rd_next[snrc_pkg::CF_HOLD_BIT] = hold_reg[li];
			rd_next[snrc_pkg::CF_SYMGAP_LSB +: 11] = sym_gap_reg[li*11 +: 11];
			rd_next[snrc_pkg::CF_TOKGAP_LSB +: 11] = tok_gap_reg[li*11 +: 11];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= rd_next;
			end
		end
	end

	// one pacer per external link; disabled links never send
	for (genvar g = 0; g < snrc_pkg::NLINK; g++) begin : g_pace
		snrc_pacer u_pacer (
			.clk(clk),
			.rst_n(rst_n),
			.sym_req(tx_sym_req[g] && enable_reg[g]),
			.sym_last(tx_sym_last[g]),
			.sym_go(tx_sym_go[g]),
			.sym_gap(sym_gap_reg[g*11 +: 11]),
			.tok_gap(tok_gap_reg[g*11 +: 11])
		);
	end

	property p_route_dim0;
		@(posedge clk) disable iff (!rst_n)
		route_req && ((route_target ^ node_id_reg) == 16'h0001) |=>
			route_valid && !route_local && route_dir == dirs_lo_reg[3:0];
	endproperty
	a_route_dim0: assert property (p_route_dim0) else $error("bad dim0 route");

	property p_route_dim15;
		@(posedge clk) disable iff (!rst_n)
		route_req && mismatch[15] |=> route_dir == dirs_hi_reg[31:28];
	endproperty
	a_route_dim15: assert property (p_route_dim15) else $error("bad dim15 route");

	property p_write_lock;
		@(posedge clk) disable iff (!rst_n)
		wp_reg && cfg_wr |=> $stable(node_id_reg) && $stable(dirs_lo_reg) && wp_reg;
	endproperty
	a_write_lock: assert property (p_write_lock) else $error("locked write took");

	property p_dbg_core1;
		@(posedge clk) disable iff (!rst_n)
		dbg_core1_event && !dbg_core0_event |=> dbg_src_reg == 2'h2;
	endproperty
	a_dbg_core1: assert property (p_dbg_core1) else $error("debug origin wrong");

	property p_credit_gain;
		@(posedge clk) disable iff (!rst_n)
		link_credit_gain[0] |=> hold_reg[0];
	endproperty
	a_credit_gain: assert property (p_credit_gain) else $error("credit gain lost");

	property p_credit_request_token;
		@(posedge clk) disable iff (!rst_n)
		wr_ok && cfg_addr == snrc_pkg::EXT_SETUP_BASE && cfg_wdata[24] &&
			!link_credit_gain[0] |=> !hold_reg[0] && link_credit_request[0]
			##1 !link_credit_request[0];
	endproperty
	a_credit_request_token: assert property (p_credit_request_token) else $error("credit request wrong");

	property p_rx_reset;
		@(posedge clk) disable iff (!rst_n)
		wr_ok && cfg_addr == snrc_pkg::EXT_SETUP_BASE && cfg_wdata[23] |=>
			link_rx_reset[0] ##1 !link_rx_reset[0];
	endproperty
	a_rx_reset: assert property (p_rx_reset) else $error("rx reset pulse wrong");

	property p_err_sticky;
		@(posedge clk) disable iff (!rst_n)
		link_rx_error[3] |=> err_reg[3] [*2];
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

	property p_sym_gap;
		@(posedge clk) disable iff (!rst_n)
		tx_sym_go[0] |=> !tx_sym_go[0];
	endproperty
	a_sym_gap: assert property (p_sym_gap) else $error("no idle gap");

	property p_ref_read;
		@(posedge clk) disable iff (!rst_n)
		cfg_rd && cfg_addr == snrc_pkg::REF_CLK_DIV |=>
			cfg_rvalid && cfg_rdata == {16'h0000, $past(ref_div_reg)};
	endproperty
	a_ref_read: assert property (p_ref_read) else $error("ref divider read wrong");
endmodule
`default_nettype wire
